// ### uart_lfc_pkg.sv
package uart_lfc_pkg;

    // Register offsets on the plain register port
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_MASK = 3'h1;
    localparam logic [2:0] ADDR_EVT = 3'h2;
    localparam logic [2:0] ADDR_LFR = 3'h3;
    localparam logic [2:0] ADDR_LSR = 3'h5;

    // Line format register fields
    localparam int LFR_DIV_ACCESS = 7;
    localparam int LFR_BREAK = 6;
    localparam int LFR_STICK = 5;
    localparam int LFR_EVEN = 4;
    localparam int LFR_PAR_EN = 3;
    localparam int LFR_STOP = 2;

    // Event status and mask layout
    localparam int EVT_RX = 0;
    localparam int EVT_THRE = 1;
    localparam int EVT_LINE = 2;

    // Line status layout
    localparam int LSR_DR = 0;
    localparam int LSR_OVR = 1;
    localparam int LSR_PERR = 2;
    localparam int LSR_FERR = 3;
    localparam int LSR_BRK = 4;
    localparam int LSR_THRE = 5;
    localparam int LSR_TEMT = 6;

    // Reset values
    localparam logic [7:0] LFR_RESET = 8'h00;
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [2:0] MASK_RESET = 3'h0;

    // Sixteen baud ticks per bit; stop lengths in ticks
    localparam logic [5:0] TX_TICKS_BIT = 6'h10;
    localparam logic [5:0] TX_TICKS_STOP1 = 6'h10;
    localparam logic [5:0] TX_TICKS_STOP15 = 6'h18;
    localparam logic [5:0] TX_TICKS_STOP2 = 6'h20;
    localparam logic [3:0] RX_MID_START = 4'h7;
    localparam logic [3:0] RX_MID_BIT = 4'hF;
    localparam logic [2:0] DATA_BITS_MIN = 3'h4;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_PAR = 3'b011,
        TX_STOP = 3'b100
    } tx_state_e;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR = 3'b011,
        RX_STOP = 3'b100
    } rx_state_e;

endpackage

// ### uart_parity_gen.sv
`timescale 1ns/1ns
module uart_parity_gen
    import uart_lfc_pkg::*;
(
    // Character and format
    input wire logic [7:0] data,
    input wire logic [1:0] size,
    input wire logic even_sel,
    input wire logic stick,
    // Expected parity bit
    output logic par_bit
);
    logic [7:0] mask_w;
    logic ones_odd_w;

    // Only the selected data bits count toward parity
    assign mask_w = 8'hFF >> (2'h3 - size);
    assign ones_odd_w = ^(data & mask_w);
    // Stick parity sends the inverse of the even select bit
    assign par_bit = stick ? ~even_sel
                   : (even_sel ? ones_odd_w : ~ones_odd_w);
endmodule

// ### uart_line_format.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ns
// What this block does
// - Divisor access bit redirects low offsets to divisor
// - Break bit holds serial output low
// - Parity enable inserts and checks parity bit
// - Even select chooses even or odd parity
// - Stick parity sends constant inverse of select
// - Stop select gives one, 1.5 or two
// - Receiver checks only the first stop bit
// - Size bits select five to eight data
// - Size counts data bits only, framing added
// - Line errors raise highest priority interrupt
module uart_line_format
    import uart_lfc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata_q,
    // Serial line
    input wire logic rxd,
    output logic txd_q,
    // Interrupt
    output logic irq_q
);
    logic [7:0] lfr_q;
    logic [15:0] div_q;
    logic [15:0] baud_cnt_q;
    logic [2:0] mask_q;
    logic [2:0] evt_q;
    logic [7:0] thr_q;
    logic thr_full_q;
    logic [7:0] rbr_q;
    logic [4:0] lsr_q;
    tx_state_e tx_state_q;
    logic [7:0] tx_data_q;
    logic [5:0] tx_cnt_q;
    logic [2:0] tx_idx_q;
    logic tx_line_q;
    rx_state_e rx_state_q;
    logic [7:0] rx_data_q;
    logic [3:0] rx_cnt_q;
    logic [2:0] rx_idx_q;
    logic rx_par_q;

    // Address decode
    logic divisor_access_select_w, sel_data_w, sel_dll_w, sel_mask_w, sel_dlm_w;
    assign divisor_access_select_w = lfr_q[LFR_DIV_ACCESS];
    assign sel_data_w = (addr == ADDR_DATA) && !divisor_access_select_w;
    assign sel_dll_w = (addr == ADDR_DATA) && divisor_access_select_w;
    assign sel_mask_w = (addr == ADDR_MASK) && !divisor_access_select_w;
    assign sel_dlm_w = (addr == ADDR_MASK) && divisor_access_select_w;
    logic wr_thr_w, rd_rbr_w, rd_evt_w, rd_lsr_w;
    assign wr_thr_w = wr_stb && sel_data_w;
    assign rd_rbr_w = rd_stb && sel_data_w;
    assign rd_evt_w = rd_stb && (addr == ADDR_EVT);
    assign rd_lsr_w = rd_stb && (addr == ADDR_LSR);

    // Baud tick at sixteen times the bit rate; divisor 0 acts as 1
    logic tick_w;
    assign tick_w = ({1'b0, baud_cnt_q} + 17'h00001) >= {1'b0, div_q};

    // Format decode: data length for both directions, stop length for transmit only
    logic [2:0] last_idx_w;
    logic [5:0] stop_ticks_w;
    assign last_idx_w = DATA_BITS_MIN + {1'b0, lfr_q[1:0]};
    assign stop_ticks_w = !lfr_q[LFR_STOP] ? TX_TICKS_STOP1
        : (lfr_q[1:0] == 2'h0 ? TX_TICKS_STOP15 : TX_TICKS_STOP2);

    // Parity generation and checking
    logic tx_par_w, rx_par_exp_w;
    uart_parity_gen u_tx_par (
        .data(tx_data_q),
        .size(lfr_q[1:0]),
        .even_sel(lfr_q[LFR_EVEN]),
        .stick(lfr_q[LFR_STICK]),
        .par_bit(tx_par_w)
    );
    uart_parity_gen u_rx_par (
        .data(rx_data_q),
        .size(lfr_q[1:0]),
        .even_sel(lfr_q[LFR_EVEN]),
        .stick(lfr_q[LFR_STICK]),
        .par_bit(rx_par_exp_w)
    );

    // Transmit timing
    logic [5:0] tx_len_w;
    logic tx_end_w, tx_load_w;
    assign tx_len_w = (tx_state_q == TX_STOP) ? stop_ticks_w
                                              : TX_TICKS_BIT;
    assign tx_end_w = tick_w && (tx_cnt_q == tx_len_w - 6'h01);
    assign tx_load_w = (tx_state_q == TX_IDLE) && thr_full_q;

    // Receive sampling at bit centres
    logic rx_mid_w, rx_done_w, par_err_w, frm_err_w, brk_w, ovr_w;
    assign rx_mid_w = tick_w && (rx_cnt_q == ((rx_state_q == RX_START)
                                 ? RX_MID_START : RX_MID_BIT));
    assign rx_done_w = (rx_state_q == RX_STOP) && rx_mid_w;
    assign par_err_w = lfr_q[LFR_PAR_EN]
                       && (rx_par_q != rx_par_exp_w);
    assign frm_err_w = !rxd;
    assign brk_w = !rxd && (rx_data_q == 8'h00)
                   && (!lfr_q[LFR_PAR_EN] || !rx_par_q);
    assign ovr_w = lsr_q[LSR_DR];

    // Sticky events; a set in the clearing cycle survives
    logic [2:0] evt_set_w;
    logic [4:0] lsr_set_w;
    assign evt_set_w[EVT_RX] = rx_done_w;
    assign evt_set_w[EVT_THRE] = tx_load_w;
    assign evt_set_w[EVT_LINE] = rx_done_w
        && (par_err_w || frm_err_w || brk_w || ovr_w);
    assign lsr_set_w = {brk_w, frm_err_w, par_err_w, ovr_w, 1'b1}
                       & {5{rx_done_w}};

    // Highest pending source: line status first
    logic [2:0] pend_w;
    logic [1:0] top_w;
    assign pend_w = evt_q & mask_q;
    assign top_w = pend_w[EVT_LINE] ? 2'h3
                 : pend_w[EVT_RX] ? 2'h2
                 : pend_w[EVT_THRE] ? 2'h1 : 2'h0;

    // Read mux
    logic [7:0] rd_mux_w;
    assign rd_mux_w = sel_data_w ? rbr_q
        : sel_dll_w ? div_q[7:0]
        : sel_mask_w ? {5'h00, mask_q}
        : sel_dlm_w ? div_q[15:8]
        : (addr == ADDR_EVT) ? {top_w, 3'h0, evt_q}
        : (addr == ADDR_LFR) ? lfr_q
        : (addr == ADDR_LSR) ? {1'b0, tx_state_q == TX_IDLE
                                && !thr_full_q, !thr_full_q, lsr_q}
        : 8'h00;

    // Software registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lfr_q <= LFR_RESET;
            div_q <= DIV_RESET;
            mask_q <= MASK_RESET;
        end else if (wr_stb) begin
            if (addr == ADDR_LFR) lfr_q <= wdata;
            if (sel_dll_w) div_q[7:0] <= wdata;
            if (sel_dlm_w) div_q[15:8] <= wdata;
            if (sel_mask_w) mask_q <= wdata[2:0];
        end
    end

    // Status, holding registers and outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            evt_q <= 3'h0;
            lsr_q <= 5'h00;
            thr_q <= 8'h00;
            thr_full_q <= 1'b0;
            rbr_q <= 8'h00;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
            txd_q <= 1'b1;
            baud_cnt_q <= 16'h0000;
        end else begin
            evt_q <= (evt_q & {3{!rd_evt_w}}) | evt_set_w;
            lsr_q[4:1] <= (lsr_q[4:1] & {4{!rd_lsr_w}}) | lsr_set_w[4:1];
            lsr_q[0] <= (lsr_q[0] && !rd_rbr_w) || lsr_set_w[0];
            if (wr_thr_w) thr_q <= wdata;
            thr_full_q <= wr_thr_w || (thr_full_q && !tx_load_w);
            if (rx_done_w) rbr_q <= rx_data_q;
            rdata_q <= rd_stb ? rd_mux_w : 8'h00;
            irq_q <= |pend_w;
            txd_q <= tx_line_q && !lfr_q[LFR_BREAK];
            baud_cnt_q <= tick_w ? 16'h0000 : baud_cnt_q + 16'h0001;
        end
    end

    // Transmit counters; the bit timer restarts after each start, data and parity bit and after the whole stop period
    always_ff @(posedge ref_clk) begin
        if (!rst_n || tx_state_q == TX_IDLE) tx_cnt_q <= 6'h00;
        else if (tick_w) tx_cnt_q <= tx_end_w ? 6'h00 : tx_cnt_q + 6'h01;
    end

    // Transmit framer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_state_q <= TX_IDLE;
            tx_data_q <= 8'h00;
            tx_idx_q <= 3'h0;
            tx_line_q <= 1'b1;
        end else begin
            unique case (tx_state_q)
                TX_IDLE: if (tx_load_w) begin
                    tx_data_q <= thr_q;
                    tx_state_q <= TX_START;
                    tx_line_q <= 1'b0;
                end
                TX_START: if (tx_end_w) begin
                    tx_state_q <= TX_DATA;
                    tx_idx_q <= 3'h0;
                    tx_line_q <= tx_data_q[0];
                end
                TX_DATA: if (tx_end_w) begin
                    if (tx_idx_q == last_idx_w) begin
                        tx_state_q <= lfr_q[LFR_PAR_EN] ? TX_PAR
                                                        : TX_STOP;
                        tx_line_q <= !lfr_q[LFR_PAR_EN] || tx_par_w;
                    end else begin
                        tx_idx_q <= tx_idx_q + 3'h1;
                        tx_line_q <= tx_data_q[tx_idx_q + 3'h1];
                    end
                end
                TX_PAR: if (tx_end_w) begin
                    tx_state_q <= TX_STOP;
                    tx_line_q <= 1'b1;
                end
                TX_STOP: if (tx_end_w) tx_state_q <= TX_IDLE;
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    // Receive deframer; extra stop bits look like idle line
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_state_q <= RX_IDLE;
            rx_data_q <= 8'h00;
            rx_cnt_q <= 4'h0;
            rx_idx_q <= 3'h0;
            rx_par_q <= 1'b0;
        end else begin
            if (tick_w) rx_cnt_q <= rx_mid_w ? 4'h0 : rx_cnt_q + 4'h1;
            unique case (rx_state_q)
                RX_IDLE: if (!rxd) begin
                    rx_state_q <= RX_START;
                    rx_cnt_q <= 4'h0;
                    rx_data_q <= 8'h00;
                end
                // A glitch shorter than half a bit is dropped
                RX_START: if (rx_mid_w) begin
                    rx_state_q <= rxd ? RX_IDLE : RX_DATA;
                    rx_idx_q <= 3'h0;
                end
                RX_DATA: if (rx_mid_w) begin
                    rx_data_q[rx_idx_q] <= rxd;
                    rx_idx_q <= rx_idx_q + 3'h1;
                    if (rx_idx_q == last_idx_w)
                        rx_state_q <= lfr_q[LFR_PAR_EN] ? RX_PAR
                                                        : RX_STOP;
                end
                RX_PAR: if (rx_mid_w) begin
                    rx_par_q <= rxd;
                    rx_state_q <= RX_STOP;
                end
                RX_STOP: if (rx_mid_w) rx_state_q <= RX_IDLE;
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic [5:0] stop_seen_q;
    logic [3:0] bits_seen_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || tx_state_q == TX_IDLE) begin
            stop_seen_q <= 6'h00;
            bits_seen_q <= 4'h0;
        end else begin
            if (tx_state_q == TX_STOP && tick_w)
                stop_seen_q <= stop_seen_q + 6'h01;
            if (tx_state_q == TX_DATA && tx_end_w)
                bits_seen_q <= bits_seen_q + 4'h1;
        end
    end

    chk_reset_clears: assert property (
        disable iff (1'b0) !rst_n |=> (lfr_q == 8'h00))
        else $error("line format not cleared by reset");
    chk_break_holds: assert property (
        lfr_q[LFR_BREAK] && $past(lfr_q[LFR_BREAK]) |-> !txd_q)
        else $error("serial output not held low in break");
    chk_div_write: assert property (
        wr_stb && sel_dll_w |=> div_q[7:0] == $past(wdata)
                                && rbr_q == $past(rbr_q))
        else $error("divisor access did not reach divisor");
    chk_frame_levels: assert property (
        (tx_state_q == TX_START |-> !tx_line_q)
        and (tx_state_q == TX_STOP |-> tx_line_q))
        else $error("start or stop level wrong");
    chk_parity_sense: assert property (
        tx_state_q == TX_PAR && !lfr_q[LFR_STICK] |->
        (^({tx_data_q & (8'hFF >> (2'h3 - lfr_q[1:0])), tx_line_q})
         == !lfr_q[LFR_EVEN]))
        else $error("parity sense wrong");
    chk_stick_parity: assert property (
        tx_state_q == TX_PAR && lfr_q[LFR_STICK] |->
        tx_line_q == !lfr_q[LFR_EVEN])
        else $error("stick parity level wrong");
    chk_parity_slot: assert property (
        tx_state_q == TX_DATA && tx_end_w && tx_idx_q == last_idx_w |=>
        tx_state_q == (lfr_q[LFR_PAR_EN] ? TX_PAR : TX_STOP))
        else $error("parity slot misplaced");
    chk_data_count: assert property (
        tx_state_q == TX_DATA ##1 tx_state_q != TX_DATA |->
        bits_seen_q == {2'b00, lfr_q[1:0]} + 4'h5)
        else $error("wrong number of data bits");
    chk_stop_length: assert property (
        tx_state_q == TX_STOP ##1 tx_state_q == TX_IDLE |->
        stop_seen_q == (!lfr_q[LFR_STOP] ? 6'h10
                        : lfr_q[1:0] == 2'h0 ? 6'h18 : 6'h20))
        else $error("stop length wrong");
    chk_rx_one_stop: assert property (
        rx_done_w |=> rx_state_q == RX_IDLE && lsr_q[LSR_DR])
        else $error("receiver waited past first stop bit");
    chk_line_irq: assert property (
        evt_set_w[EVT_LINE] && mask_q[EVT_LINE] |=> ##1 irq_q)
        else $error("line status did not raise interrupt");

    cov_break: cover property (lfr_q[LFR_BREAK] && !txd_q);
    cov_tx_parity: cover property (tx_state_q == TX_PAR ##1
                                   tx_state_q == TX_STOP);
    cov_rx_error: cover property (rx_done_w && par_err_w);
    cov_irq: cover property ($rose(irq_q));
endmodule

// ### serial_terminal_model.sv
`timescale 1ns/1ns
module serial_terminal_model (
    // Clock that paces bit times
    input wire logic ref_clk,
    // Serial lines seen from the terminal
    input wire logic txd,
    output logic rxd
);
    // Marking while idle; no pull needed, line is driven
    initial rxd = 1'b1;

    // Send bits LSB first, sixteen clocks each
    task automatic send_frame(input logic [23:0] bits, input int len);
        for (int i = 0; i < len; i++) begin
            @(posedge ref_clk);
            rxd <= bits[i];
            repeat (15) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        rxd <= 1'b1;
    endtask

    // Sample a frame at bit centres; unsampled bits read as one
    task automatic get_frame(input int len, output logic [11:0] bits,
        output time t0);
        bits = '1;
        @(negedge txd);
        t0 = $time;
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < len; i++) begin
            bits[i] = txd;
            if (i < len - 1) repeat (16) @(posedge ref_clk);
        end
    endtask
endmodule

// ### uart_line_format_control_tb_top.sv
`timescale 1ns/1ns
module uart_line_format_control_tb_top;
    import uart_lfc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rdata_q;
    logic rxd;
    logic txd_q;
    logic irq_q;
    int num_errors = 0;
    int checks = 0;
    int seed = 32'h80bc;
    logic [7:0] fmt [8] = '{8'h00, 8'h04, 8'h09, 8'h1E, 8'h2B, 8'h3F,
        8'h38, 8'h1A};
    logic [7:0] d0, d1, r;
    logic [11:0] f0, f1;
    time t0, t1;

    always #4 ref_clk = ~ref_clk;

    uart_line_format uart_line_format_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata_q(rdata_q), .rxd(rxd), .txd_q(txd_q), .irq_q(irq_q));
    serial_terminal_model serial_terminal_model_i (.ref_clk(ref_clk),
        .txd(txd_q), .rxd(rxd));

    // Expected frame: start, data LSB first, parity, stops as ones
    function automatic logic [11:0] exp_frame(input logic [7:0] d,
        input logic [7:0] f, input logic flip);
        int n;
        logic p;
        logic [11:0] q;
        n = 5 + f[1:0];
        p = f[5] ? ~f[4] : (^(d & ((8'h01 << n) - 1))) ^ ~f[4];
        q = '1;
        q[0] = 1'b0;
        for (int i = 0; i < n; i++) q[i + 1] = d[i];
        if (f[3]) q[n + 1] = p ^ flip;
        return q;
    endfunction

    // Bits up to and including the first stop
    function automatic int flen(input logic [7:0] f);
        return 7 + f[1:0] + f[3];
    endfunction

    // Clocks from one start edge to the end of its stop bits
    function automatic int fper(input logic [7:0] f);
        return 16 * (flen(f) - 1) + (f[2] ? (f[1:0] == 0 ? 24 : 32) : 16);
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 d = rdata_q;
    endtask

    task automatic close_out;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Cut a hang short well beyond the expected run
    initial begin
        #400000;
        num_errors++;
        close_out;
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        check(txd_q, 1'b1);
        reg_rd(ADDR_LFR, r);
        check(r, LFR_RESET);
        reg_rd(3'h7, r);
        check(r, 8'h00);
        $display("test reset done");
        // Mask lives at offset 1 only while divisor access is clear
        reg_wr(ADDR_MASK, 8'h04);
        reg_wr(ADDR_LFR, 8'h80);
        reg_wr(ADDR_MASK, 8'h5A);
        reg_rd(ADDR_MASK, r);
        check(r, 8'h5A);
        reg_wr(ADDR_MASK, 8'h00);
        reg_wr(ADDR_DATA, 8'h01);
        reg_rd(ADDR_DATA, r);
        check(r, 8'h01);
        reg_wr(ADDR_LFR, 8'h00);
        reg_rd(ADDR_MASK, r);
        check(r, 8'h04);
        $display("test access done");
        // Two back-to-back characters per format expose stop length
        foreach (fmt[k]) begin
            d0 = $random(seed);
            d1 = $random(seed);
            reg_wr(ADDR_LFR, fmt[k]);
            fork
                begin
                    serial_terminal_model_i.get_frame(flen(fmt[k]), f0, t0);
                    serial_terminal_model_i.get_frame(flen(fmt[k]), f1, t1);
                end
                begin
                    reg_wr(ADDR_DATA, d0);
                    repeat (4) @(posedge ref_clk);
                    reg_wr(ADDR_DATA, d1);
                end
            join
            check(f0, exp_frame(d0, fmt[k], 1'b0));
            check(f1, exp_frame(d1, fmt[k], 1'b0));
            // One idle clock while the shifter reloads the next byte
            check((t1 - t0) / 8, fper(fmt[k]) + 1);
            repeat (40) @(posedge ref_clk);
        end
        $display("test transmit done");
        // Receive good parity in every format, then corrupted parity in formats with parity enabled
        foreach (fmt[k]) begin
            d0 = $random(seed);
            reg_wr(ADDR_LFR, fmt[k]);
            serial_terminal_model_i.send_frame(exp_frame(d0, fmt[k], 1'b0),
                flen(fmt[k]));
            reg_rd(ADDR_DATA, r);
            check(r, d0 & ((8'h01 << (5 + fmt[k][1:0])) - 1));
            reg_rd(ADDR_LSR, r);
            check(r & 8'h0E, 8'h00);
            if (fmt[k][3]) begin
                serial_terminal_model_i.send_frame(
                    exp_frame(d0, fmt[k], 1'b1), flen(fmt[k]));
                reg_rd(ADDR_LSR, r);
                check(r & 8'h04, 8'h04);
                reg_rd(ADDR_DATA, r);
            end
        end
        reg_rd(ADDR_EVT, r);
        $display("test receive done");
        // Line error raises the top interrupt; read clears, mask blocks
        reg_wr(ADDR_LFR, 8'h08);
        serial_terminal_model_i.send_frame(exp_frame(8'h13, 8'h08, 1'b1), 8);
        repeat (4) @(posedge ref_clk);
        check(irq_q, 1'b1);
        reg_rd(ADDR_EVT, r);
        check(r & 8'hC4, 8'hC4);
        reg_rd(ADDR_LSR, r);
        reg_rd(ADDR_DATA, r);
        repeat (2) @(posedge ref_clk);
        check(irq_q, 1'b0);
        reg_wr(ADDR_MASK, 8'h00);
        serial_terminal_model_i.send_frame(exp_frame(8'h13, 8'h08, 1'b1), 8);
        repeat (4) @(posedge ref_clk);
        check(irq_q, 1'b0);
        reg_rd(ADDR_DATA, r);
        $display("test interrupt done");
        // One stop per frame while two are configured: no framing error
        d0 = $random(seed);
        d1 = $random(seed);
        reg_wr(ADDR_LFR, 8'h07);
        reg_rd(ADDR_LSR, r);
        f0 = exp_frame(d0, 8'h03, 1'b0);
        f1 = exp_frame(d1, 8'h03, 1'b0);
        fork
            serial_terminal_model_i.send_frame({4'hF, f1[9:0], f0[9:0]},
                20);
            begin
                repeat (168) @(posedge ref_clk);
                reg_rd(ADDR_DATA, r);
                check(r, d0);
            end
        join
        reg_rd(ADDR_DATA, r);
        check(r, d1);
        reg_rd(ADDR_LSR, r);
        check(r & 8'h0A, 8'h00);
        $display("test stop sampling done");
        // All-zero frame with a low stop: framing error and break
        reg_wr(ADDR_LFR, 8'h00);
        reg_rd(ADDR_EVT, r);
        serial_terminal_model_i.send_frame(24'h000000, 7);
        repeat (16) @(posedge ref_clk);
        reg_rd(ADDR_LSR, r);
        check(r & 8'h18, 8'h18);
        reg_rd(ADDR_EVT, r);
        check(r & 8'h04, 8'h04);
        reg_rd(ADDR_DATA, r);
        check(r, 8'h00);
        $display("test line error done");
        // Break holds the line low even while a character is sent
        reg_wr(ADDR_LFR, 8'h40);
        repeat (2) @(posedge ref_clk);
        check(txd_q, 1'b0);
        reg_wr(ADDR_DATA, 8'hFF);
        repeat (60) @(posedge ref_clk);
        check(txd_q, 1'b0);
        reg_wr(ADDR_LFR, 8'h00);
        repeat (300) @(posedge ref_clk);
        check(txd_q, 1'b1);
        $display("test break done");
        close_out;
    end
endmodule
